// ---- hw/frc_codec.sv ----
/*
  Five-line remote frame encoder and decoder with a two-entry output buffer.
  Assumes function inputs and the received serial line are synchronous to sys_clk.
*/
`timescale 1ns/1ps
// Summary of operation
// (RULE1) Frame: six preamble symbols, parity, polarity, then data symbols in order.
// (RULE2) Parity symbol carries even parity over the five data bits.
// (RULE3) Polarity symbol alternates positive and negative from frame to frame.
// (RULE4) Five data symbols, line zero first, line four last.
// (RULE5) Preamble symbol is sent as 101.
// (RULE6) Active symbol is sent as 100.
// (RULE7) Inactive symbol is sent as 110.
// (RULE8) Any active input enables the oscillator and power amplifier.
// (RULE9) Frames repeat back to back while any input stays active.
// (RULE10) After all inputs drop, send fifteen all-zero frames, then stop.
// (RULE11) Activity on the serial input wakes the decoder to check a frame.
// (RULE12) After reset the decoder waits in standby.
// (RULE13) Preamble or symbol error discards the frame and returns to standby.
// (RULE14) A good frame's five bits are stored and compared with the previous.
// (RULE15) Outputs update only after two consecutive equal good frames.
// (RULE16) Output pairs one-zero and three-two are never active together.
// (RULE17) Frame rate is the clock divided by 64 then by 33.
// (RULE18) Decoder measures received bit width and samples in step with it.
// (RULE19) Active input sends active symbol, inactive sends inactive; decoder maps back.
// (RULE20) Parity mismatch rejects the frame as a symbol error.
module frc_codec (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Encoder function lines and radio side.
  input wire logic [4:0] fn_in,
  output logic radio_tx_output,
  output logic tx_enable,
  // Decoder serial input and decoded lines.
  input wire logic rx_din,
  output logic [4:0] dec_out,
  // Decoded word stream.
  output logic word_valid,
  output logic [4:0] word_data,
  input wire logic word_ready
);

  typedef struct packed {
    frc_pkg::frc_enc_st_t est;
    logic [11:0] fc;
    logic [7:0] bt;
    logic [5:0] ebi;
    logic [1:0] esb;
    logic [38:0] esh;
    logic tx;
    logic txen;
    logic pol;
    logic gap;
    logic [3:0] tail;
    frc_pkg::frc_dec_st_t dst;
    logic din_q;
    logic [7:0] w;
    logic [7:0] ph;
    logic [5:0] bc;
    logic [1:0] sbit;
    logic [38:0] dsh;
    logic [4:0] prev;
    logic prev_ok;
    logic [4:0] pend;
    logic [4:0] dout;
  } frc_top_state_t;

  frc_top_state_t q;
  frc_top_state_t d;
  logic frame_ok;
  logic [4:0] frame_data;
  logic rise;
  logic pop;

  frc_stream_if push_s ();
  frc_stream_if pop_s ();

  frc_buf u_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_s(push_s.snk),
    .out_s(pop_s.src)
  );

  assign push_s.valid = (q.dst == frc_pkg::FRC_DS_PUSH);
  assign push_s.data = q.pend;
  assign word_valid = pop_s.valid;
  assign word_data = pop_s.data;
  assign pop_s.ready = word_ready;
  assign pop = pop_s.valid && word_ready;
  assign radio_tx_output = q.tx;
  assign tx_enable = q.txen;
  assign dec_out = q.dout;
  assign rise = rx_din && !q.din_q;

  // Checks the collected frame and extracts its data bits.
  always_comb
  begin
    logic [1:0] sd;
    sd = 2'h0;
    frame_ok = 1'b1;
    frame_data = frc_pkg::DATA_RST;
    for (int i = 0; i < frc_pkg::PRE_SYMS; i++)
    begin
      if (q.dsh[38 - 3 * i -: 3] != frc_pkg::SYM_PRE)
      begin
        frame_ok = 1'b0; // [RULE13]
      end
    end
    for (int i = 0; i < frc_pkg::FN_W; i++)
    begin
      sd = frc_pkg::frc_sym_dec(q.dsh[38 - 3 * (frc_pkg::DATA_SYM + i) -: 3]);
      frame_data[i] = sd[0]; // [RULE4] [RULE19]
      frame_ok = frame_ok && sd[1]; // [RULE13]
    end
    sd = frc_pkg::frc_sym_dec(q.dsh[38 - 3 * frc_pkg::POL_SYM -: 3]);
    frame_ok = frame_ok && sd[1];
    sd = frc_pkg::frc_sym_dec(q.dsh[38 - 3 * frc_pkg::PAR_SYM -: 3]);
    frame_ok = frame_ok && sd[1] && (sd[0] == ^frame_data); // [RULE20]
  end

  always_comb
  begin
    logic start;
    logic [4:0] sdata;
    logic [38:0] fb;
    start = 1'b0;
    sdata = frc_pkg::DATA_RST;
    fb = frc_pkg::FRAME_RST;
    d = q;
    d.din_q = rx_din;
    // Encoder.
    unique case (q.est)
      frc_pkg::FRC_ES_IDLE:
      begin
        if (|fn_in)
        begin
          start = 1'b1; // [RULE8]
          sdata = fn_in;
          d.tail = 4'h0;
        end
      end
      frc_pkg::FRC_ES_SEND:
      begin
        d.fc = q.fc + 12'h1;
        if (q.fc == frc_pkg::FRAME_CLKS - 12'h1)
        begin
          if (|fn_in)
          begin
            start = 1'b1; // [RULE9]
            sdata = fn_in;
            d.tail = 4'h0;
          end
          else if (q.tail < frc_pkg::TAIL_FRAMES)
          begin
            start = 1'b1; // [RULE10]
            d.tail = q.tail + 4'h1;
          end
          else
          begin
            d.est = frc_pkg::FRC_ES_IDLE; // [RULE10]
            d.txen = 1'b0;
            d.tx = 1'b0;
          end
        end
        else if (!q.gap)
        begin
          d.bt = q.bt + 8'h1;
          if (q.bt == frc_pkg::BIT_CLKS - 8'h1)
          begin
            d.bt = 8'h0;
            if (q.ebi == frc_pkg::LAST_BIT)
            begin
              d.gap = 1'b1; // [RULE17]
              d.tx = 1'b0;
            end
            else
            begin
              d.ebi = q.ebi + 6'h1;
              d.esb = (q.esb == frc_pkg::SYM_LAST) ? 2'h0 : q.esb + 2'h1;
              d.tx = q.esh[38];
              d.esh = {q.esh[37:0], 1'b0};
            end
          end
        end
      end
    endcase
    if (start)
    begin
      fb = frc_pkg::frc_frame_bits(sdata, ~q.pol); // [RULE1] [RULE2] [RULE3]
      d.est = frc_pkg::FRC_ES_SEND;
      d.txen = 1'b1;
      d.pol = ~q.pol;
      d.fc = 12'h0;
      d.bt = 8'h0;
      d.ebi = 6'h0;
      d.esb = 2'h0;
      d.gap = 1'b0;
      d.tx = fb[38];
      d.esh = {fb[37:0], 1'b0};
    end
    // Decoder.
    unique case (q.dst)
      frc_pkg::FRC_DS_STANDBY:
      begin
        if (rise)
        begin
          d.dst = frc_pkg::FRC_DS_MEASURE; // [RULE11]
          d.w = 8'h1;
        end
      end
      frc_pkg::FRC_DS_MEASURE:
      begin
        if (!rx_din)
        begin
          if (q.w < frc_pkg::BIT_MIN)
          begin
            d.dst = frc_pkg::FRC_DS_STANDBY;
          end
          else
          begin
            d.dst = frc_pkg::FRC_DS_SAMPLE;
            d.ph = q.w >> 1; // [RULE18]
            d.dsh = 39'h1;
            d.bc = 6'h1;
            d.sbit = 2'h1;
          end
        end
        else if (q.w == frc_pkg::BIT_MAX)
        begin
          d.dst = frc_pkg::FRC_DS_STANDBY;
        end
        else
        begin
          d.w = q.w + 8'h1;
        end
      end
      frc_pkg::FRC_DS_SAMPLE:
      begin
        d.ph = q.ph - 8'h1;
        if (q.ph == 8'h0)
        begin
          d.dsh = {q.dsh[37:0], rx_din};
          d.bc = q.bc + 6'h1;
          d.sbit = q.sbit + 2'h1;
          d.ph = q.w - 8'h1; // [RULE18]
          if (q.bc == frc_pkg::LAST_BIT)
          begin
            d.dst = frc_pkg::FRC_DS_CHECK;
          end
          else if (q.sbit == frc_pkg::SYM_LAST)
          begin
            // A symbol that ends high has no rise at its boundary, so timing runs on.
            d.sbit = 2'h0; // [RULE18]
            if (!rx_din)
            begin
              d.dst = frc_pkg::FRC_DS_WAITRISE;
              d.ph = 8'h0;
            end
          end
        end
      end
      frc_pkg::FRC_DS_WAITRISE:
      begin
        d.ph = q.ph + 8'h1;
        if (rise)
        begin
          d.dst = frc_pkg::FRC_DS_SAMPLE;
          d.ph = q.w >> 1; // [RULE18]
          d.sbit = 2'h0;
        end
        else if (q.ph == q.w)
        begin
          d.dst = frc_pkg::FRC_DS_STANDBY; // [RULE13]
          d.prev_ok = 1'b0;
        end
      end
      frc_pkg::FRC_DS_CHECK:
      begin
        d.dst = frc_pkg::FRC_DS_STANDBY; // [RULE13]
        d.prev_ok = frame_ok;
        if (frame_ok)
        begin
          d.prev = frame_data; // [RULE14]
          if (q.prev_ok && (q.prev == frame_data))
          begin
            d.dst = frc_pkg::FRC_DS_PUSH; // [RULE15]
            d.pend = frame_data[1:0] != 2'h0 ? {frame_data[4], 2'h0, frame_data[1:0]} :
              frame_data; // [RULE16]
          end
        end
      end
      frc_pkg::FRC_DS_PUSH:
      begin
        if (push_s.ready)
        begin
          d.dst = frc_pkg::FRC_DS_STANDBY; // [RULE15]
        end
      end
      default:
      begin
        d.dst = frc_pkg::FRC_DS_STANDBY;
      end
    endcase
    if (pop)
    begin
      d.dout = pop_s.data; // [RULE15]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      q <= '0; // [RULE12]
    end
    else
    begin
      q <= d;
    end
  end

  property p_pre;
    @(posedge sys_clk) disable iff (!resetn)
    (q.est == frc_pkg::FRC_ES_SEND && !q.gap && q.ebi < frc_pkg::PRE_BITS)
      |-> (q.tx == frc_pkg::SYM_PRE[frc_pkg::SYM_LAST - q.esb]);
  endproperty
  a_pre: assert property (p_pre) else $error("Preamble bit wrong."); // [RULE1] [RULE5]

  property p_sym_shape;
    @(posedge sys_clk) disable iff (!resetn)
    (q.est == frc_pkg::FRC_ES_SEND && !q.gap && q.ebi >= frc_pkg::PRE_BITS)
      |-> (q.esb == 2'h0 ? q.tx : (q.esb == 2'h2 ? !q.tx : 1'b1));
  endproperty
  a_sym_shape: assert property (p_sym_shape) else $error("Symbol shape wrong."); // [RULE6] [RULE7]

  property p_txen;
    @(posedge sys_clk) disable iff (!resetn)
    (q.est == frc_pkg::FRC_ES_IDLE && |fn_in) |=> (tx_enable && radio_tx_output);
  endproperty
  a_txen: assert property (p_txen) else $error("Transmitter not enabled."); // [RULE8]

  property p_pol;
    @(posedge sys_clk) disable iff (!resetn)
    (q.est == frc_pkg::FRC_ES_SEND && q.fc == frc_pkg::FRAME_CLKS - 12'h1 && |fn_in)
      |=> (q.pol != $past(q.pol) && q.fc == 12'h0);
  endproperty
  a_pol: assert property (p_pol) else $error("Polarity did not alternate."); // [RULE3] [RULE9]

  property p_tail;
    @(posedge sys_clk) disable iff (!resetn)
    (q.fc == frc_pkg::FRAME_CLKS - 12'h1 && q.tail == frc_pkg::TAIL_FRAMES && fn_in == 5'h00)
      |=> (!tx_enable && !radio_tx_output);
  endproperty
  a_tail: assert property (p_tail) else $error("Encoder did not stop after tail."); // [RULE10]

  property p_gap;
    @(posedge sys_clk) disable iff (!resetn)
    (q.est == frc_pkg::FRC_ES_SEND && q.fc == frc_pkg::FRAME_CLKS - 12'h1) |-> q.gap;
  endproperty
  a_gap: assert property (p_gap) else $error("Frame overran its period."); // [RULE17]

  property p_wake;
    @(posedge sys_clk) disable iff (!resetn)
    (q.dst == frc_pkg::FRC_DS_STANDBY && rise) |=> (q.dst == frc_pkg::FRC_DS_MEASURE);
  endproperty
  a_wake: assert property (p_wake) else $error("Decoder did not wake."); // [RULE11]

  property p_reject;
    @(posedge sys_clk) disable iff (!resetn)
    (q.dst == frc_pkg::FRC_DS_CHECK && !frame_ok)
      |=> (q.dst == frc_pkg::FRC_DS_STANDBY && !q.prev_ok);
  endproperty
  a_reject: assert property (p_reject) else $error("Bad frame not dropped."); // [RULE13] [RULE20]

  property p_confirm;
    @(posedge sys_clk) disable iff (!resetn)
    (q.dst == frc_pkg::FRC_DS_CHECK && frame_ok && q.prev_ok && q.prev == frame_data)
      |=> (word_valid || push_s.valid) [*2];
  endproperty
  a_confirm: assert property (p_confirm) else $error("Confirmed frame not delivered."); // [RULE15]

  property p_excl;
    @(posedge sys_clk) disable iff (!resetn)
    !((|dec_out[1:0]) && (|dec_out[3:2]));
  endproperty
  a_excl: assert property (p_excl) else $error("Exclusive output pairs both active."); // [RULE16]

  property p_sync;
    @(posedge sys_clk) disable iff (!resetn)
    (q.dst == frc_pkg::FRC_DS_MEASURE && !rx_din && q.w >= frc_pkg::BIT_MIN)
      |=> (q.ph == ($past(q.w) >> 1) && q.dst == frc_pkg::FRC_DS_SAMPLE);
  endproperty
  a_sync: assert property (p_sync) else $error("Sampling not aligned to bit width."); // [RULE18]

endmodule

// ---- inc/frc_pkg.sv ----
/*
  Shared constants, state codes and symbol helpers for the five-line remote
  frame codec. Assumes a single 10 MHz system clock drives both codec halves.
*/
package frc_pkg;

  // Frame layout.
  localparam int FN_W = 5;
  localparam int PRE_SYMS = 6;
  localparam int PAR_SYM = 6;
  localparam int POL_SYM = 7;
  localparam int DATA_SYM = 8;
  localparam int FRAME_SYMS = 13;
  localparam int SYM_BITS = 3;
  localparam int FRAME_BITS = FRAME_SYMS * SYM_BITS;
  localparam logic [5:0] LAST_BIT = 6'h26;
  localparam logic [5:0] PRE_BITS = 6'h12;
  localparam logic [1:0] SYM_LAST = 2'h2;

  // Symbol patterns, sent most significant bit first.
  localparam logic [2:0] SYM_PRE = 3'h5;
  localparam logic [2:0] SYM_ACT = 3'h4;
  localparam logic [2:0] SYM_INACT = 3'h6;

  // Timing: one frame lasts the oscillator period times 64 times 33.
  localparam int OSC_DIV = 64;
  localparam int RATE_DIV = 33;
  localparam logic [11:0] FRAME_CLKS = 12'(OSC_DIV * RATE_DIV);
  localparam logic [7:0] BIT_CLKS = 8'h20;
  localparam logic [7:0] BIT_MIN = 8'h04;
  localparam logic [7:0] BIT_MAX = 8'hff;
  localparam logic [3:0] TAIL_FRAMES = 4'hf;

  // Reset values.
  localparam logic [4:0] DATA_RST = 5'h00;
  localparam logic [38:0] FRAME_RST = 39'h0;

  typedef enum logic [0:0] {
    FRC_ES_IDLE = 1'b0,
    FRC_ES_SEND = 1'b1
  } frc_enc_st_t;

  typedef enum logic [2:0] {
    FRC_DS_STANDBY = 3'b000,
    FRC_DS_MEASURE = 3'b001,
    FRC_DS_SAMPLE = 3'b010,
    FRC_DS_WAITRISE = 3'b011,
    FRC_DS_CHECK = 3'b100,
    FRC_DS_PUSH = 3'b101
  } frc_dec_st_t;

  function automatic logic [2:0] frc_sym_enc(input logic b);
    return b ? SYM_ACT : SYM_INACT;
  endfunction

  // Returns {valid, value} for a data or control symbol.
  function automatic logic [1:0] frc_sym_dec(input logic [2:0] s);
    return (s == SYM_ACT) ? 2'h3 : ((s == SYM_INACT) ? 2'h2 : 2'h0);
  endfunction

  function automatic logic [38:0] frc_frame_bits(input logic [4:0] d, input logic pol);
    logic [38:0] f;
    f = {{PRE_SYMS{SYM_PRE}}, frc_sym_enc(^d), frc_sym_enc(pol), 15'h0};
    for (int i = 0; i < FN_W; i++)
    begin
      f[14 - 3 * i -: 3] = frc_sym_enc(d[i]);
    end
    return f;
  endfunction

endpackage

// ---- inc/frc_stream_if.sv ----
/*
  Valid/ready word carrier between the codec core and its output buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface frc_stream_if;
  logic valid;
  logic ready;
  logic [4:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- hw/frc_buf.sv ----
/*
  Two-entry word buffer with valid and ready on both sides.
  Assumes a synchronous active-low reset on the system clock.
*/
`timescale 1ns/1ps
module frc_buf (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Filling side.
  frc_stream_if.snk in_s,
  // Draining side.
  frc_stream_if.src out_s
);

  typedef struct packed {
    logic [1:0][4:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } frc_buf_state_t;

  frc_buf_state_t q;
  frc_buf_state_t d;
  logic push;
  logic pop;

  assign in_s.ready = (q.cnt != 2'h2);
  assign out_s.valid = (q.cnt != 2'h0);
  assign out_s.data = q.mem[q.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_s.data;
      d.wp = ~q.wp;
    end
    if (pop)
    begin
      d.rp = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  property p_buf_hold;
    @(posedge sys_clk) disable iff (!resetn)
    (out_s.valid && !out_s.ready) |=> (out_s.valid && $stable(out_s.data));
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("Buffered word changed while stalled.");

endmodule

// ---- testbench/frc_radio_link.sv ----
/*
  Radio link model: transmitter and receiver front end from encoder to decoder.
  Assumes the system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module frc_radio_link #(
  parameter int DELAY = 3
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Transmit side.
  input wire logic tx_bit,
  input wire logic tx_on,
  input wire logic flip,
  // Receive side.
  output logic rx_bit
);
  logic [DELAY-1:0] bit_q;
  logic [DELAY-1:0] on_q;
  logic [5:0] noise_q;

  // The air path delays the stream; flip corrupts it only on command.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      bit_q <= '0;
      on_q <= '0;
      noise_q <= 6'h00;
    end
    else
    begin
      bit_q <= {bit_q[DELAY-2:0], tx_bit ^ flip};
      on_q <= {on_q[DELAY-2:0], tx_on};
      noise_q <= noise_q + 6'h01;
    end
  end

  // With the carrier off the receiver shows short noise spikes, not a quiet line.
  assign rx_bit = on_q[DELAY-1] ? bit_q[DELAY-1] : (noise_q == 6'h3f);
endmodule

// ---- testbench/five_line_remote_frame_codec_tb_top.sv ----
/*
  Self-checking bench for the codec: encoder looped to decoder over a radio model.
  Assumes a 10 MHz clock and the frame timing of the codec package.
*/
`timescale 1ns/1ps
module five_line_remote_frame_codec_tb_top;
  localparam int FRAME = 2112;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] fn_in = 5'h00;
  logic word_ready = 1'b0;
  logic flip = 1'b0;
  logic radio_tx_output;
  logic tx_enable;
  logic rx_din;
  logic word_valid;
  logic [4:0] dec_out;
  logic [4:0] word_data;
  logic [4:0] v = 5'h00;
  logic [4:0] exp_out = 5'h00;
  logic [4:0] first_out = 5'h00;
  logic [38:0] got;
  int fails = 0;
  int comparisons = 0;
  int nw = 0;
  int skip = 0;
  int cyc = 0;
  int first_pop = 0;
  int f1_start = 0;
  int n = 0;
  bit run = 1'b0;
  bit hold_err = 1'b0;
  bit tail_err = 1'b0;
  bit gap_err = 1'b0;

  always #50 sys_clk = ~sys_clk;

  frc_codec DUT (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .fn_in(fn_in),
    .radio_tx_output(radio_tx_output),
    .tx_enable(tx_enable),
    .rx_din(rx_din),
    .dec_out(dec_out),
    .word_valid(word_valid),
    .word_data(word_data),
    .word_ready(word_ready)
  );

  frc_radio_link #(.DELAY(3)) link (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tx_bit(radio_tx_output),
    .tx_on(tx_enable),
    .flip(flip),
    .rx_bit(rx_din)
  );

  function automatic logic [2:0] sym_of(input logic b);
    return b ? 3'h4 : 3'h6;
  endfunction

  function automatic logic [38:0] exp_frame(input logic [4:0] d, input logic pol);
    return {{6{3'h5}}, sym_of(^d), sym_of(pol), sym_of(d[0]), sym_of(d[1]),
      sym_of(d[2]), sym_of(d[3]), sym_of(d[4])};
  endfunction

  task automatic cmp_frame(input logic [38:0] g, input logic [38:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch t=%0t frame got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_word(input logic [4:0] g, input logic [4:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch t=%0t word got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_flag(input bit ok, input string what);
    comparisons++;
    if (!ok)
    begin
      fails++;
      $display("mismatch t=%0t %s", $time, what);
    end
  endtask

  task automatic end_sim;
    $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Samples one frame at bit centres; optionally flips the first data bit's middle.
  task automatic capture(input bit corrupt);
    for (int i = 0; i < FRAME; i++)
    begin
      if (i % 32 == 16 && i < 1248) got[38 - i / 32] = radio_tx_output;
      if (i >= 1248 && radio_tx_output !== 1'b0) gap_err = 1'b1;
      if (tx_enable !== 1'b1) gap_err = 1'b1;
      flip <= corrupt && i >= 804 && i < 828;
      @(posedge sys_clk);
    end
  endtask

  // Consumer with random stalls; tracks what the decoded lines must show.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (run)
    begin
      word_ready <= 1'($urandom_range(1, 0));
      if (skip > 0)
      begin
        skip--;
        if (skip == 0 && nw == 1) first_out = dec_out;
      end
      else if (dec_out !== exp_out || (|dec_out[1:0] && |dec_out[3:2]))
        hold_err = 1'b1;
      if (word_valid === 1'b1 && word_ready === 1'b1)
      begin
        if (nw == 0) first_pop = cyc;
        if (nw > 0 && word_data !== 5'h00) tail_err = 1'b1;
        exp_out = (nw == 0) ? (v & 5'h13) : 5'h00;
        nw++;
        skip = 2;
      end
    end
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    end_sim;
  end

  initial
  begin
    void'($urandom(86));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cmp_flag(tx_enable === 1'b0 && word_valid === 1'b0 && dec_out === 5'h00, "reset");
    run <= 1'b1;
    v = 5'($urandom) | 5'h05;
    fn_in <= v;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (tx_enable !== 1'b1 && n < 10);
    cmp_flag(n == 2, "enable delay");
    f1_start = cyc;
    capture(1'b0);
    cmp_frame(got, exp_frame(v, 1'b1));
    capture(1'b1);
    cmp_frame(got, exp_frame(v, 1'b0));
    capture(1'b0);
    cmp_frame(got, exp_frame(v, 1'b1));
    cmp_flag(!gap_err, "frame gap");
    fn_in <= 5'h00;
    n = 0;
    while (tx_enable === 1'b1 && n < 40000)
    begin
      @(posedge sys_clk);
      n++;
    end
    cmp_flag(n >= 16 * FRAME - 2 && n <= 16 * FRAME + 2, "tail length");
    repeat (200) @(posedge sys_clk);
    n = first_pop - f1_start;
    cmp_flag(n > 3 * FRAME && n < 4 * FRAME, "bad frame kept");
    cmp_word(first_out, v & 5'h13);
    cmp_flag(nw == 15, "word count");
    cmp_flag(!hold_err, "output hold");
    cmp_flag(!tail_err, "tail data");
    end_sim;
  end
endmodule
